/* File: common/wwr_pkg.sv */
// Package of constants and types for the windowed watchdog reset supervisor
package wwr_pkg;
  localparam int NUM_CH = 3;
  localparam int CH_BOOST = 0;
  localparam int CH_BUCK_A = 1;
  localparam int CH_BUCK_B = 2;

  // Timing, figures in ns, cycles derived from the clock period
  localparam int CLK_PERIOD_NS = 20;
  localparam int RST_TIMEOUT_NS = 7400000;
  localparam int SS_BOOST_NS = 1900000;
  localparam int SS_BUCK_NS = 2500000;
  localparam int RST_TIMEOUT_CYC = (RST_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SS_BOOST_CYC = (SS_BOOST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SS_BUCK_CYC = (SS_BUCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 19;

  // Watchdog window figures in ticks
  localparam int TICK_W = 16;
  localparam logic [TICK_W-1:0] MASK_TICKS_0 = 16'h0010;
  localparam logic [TICK_W-1:0] MASK_TICKS_1 = 16'h0040;
  localparam logic [TICK_W-1:0] RATIO_0 = 16'h0008;
  localparam logic [TICK_W-1:0] RATIO_1 = 16'h0010;
  localparam logic [TICK_W-1:0] FIRST_EXTRA_0 = 16'h0040;
  localparam logic [TICK_W-1:0] FIRST_EXTRA_1 = 16'h0080;
  localparam logic [TICK_W-1:0] ONE_TICK = 16'h0001;

  // Avalon register map (byte addresses)
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_OPTION = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_TICKS = 4'h8;

  // Option register fields
  localparam int OPT_W = 6;
  localparam logic [OPT_W-1:0] OPTION_RESET = 6'h00;
  localparam int OPT_SUP_LSB = 0;
  localparam int OPT_FIRST_EXTRA = 3;
  localparam int OPT_MASK_CNT = 4;
  localparam int OPT_RATIO = 5;

  // Status register fields
  localparam int ST_RESET_LSB = 0;
  localparam int ST_RUN_LSB = 3;
  localparam int ST_SHORT_LSB = 6;
  localparam int ST_PHASE_LSB = 9;
  localparam int ST_PHASE_W = 3;

  typedef enum logic [2:0] {WWR_IDLE, WWR_FIRST_OPEN, WWR_MASK, WWR_OPEN, WWR_TRIP} wwr_wd_state_t;
  typedef enum logic [1:0] {WWR_CH_OFF, WWR_CH_RAMP, WWR_CH_HOLD, WWR_CH_GOOD} wwr_ch_state_t;
endpackage

/* File: common/wwr_ch_if.sv */
// Interface between the watchdog core and one channel supervisor
`timescale 1ns/1ps
interface wwr_ch_if;
  logic en;
  logic in_window;
  logic pin_high;
  logic fb_open;
  logic wd_reset;
  logic run;
  logic reset_drive;
  logic shorted;
  modport core (output en, output in_window, output pin_high, output fb_open, output wd_reset,
                input run, input reset_drive, input shorted);
  modport chan (input en, input in_window, input pin_high, input fb_open, input wd_reset,
                output run, output reset_drive, output shorted);
endinterface

/* File: design/wwr_channel.sv */
// Per-channel soft-start, reset timeout and fault supervision
`timescale 1ns/1ps
module wwr_channel
  import wwr_pkg::*;
#(
  parameter int SS_CYC = SS_BUCK_CYC,
  parameter int RST_CYC = RST_TIMEOUT_CYC
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  wwr_ch_if.chan ch
);
  wwr_ch_state_t state_reg;
  wwr_ch_state_t state_next;
  logic [TMR_W-1:0] tmr_reg;
  logic [TMR_W-1:0] tmr_next;
  logic shorted_reg;
  logic shorted_next;
  logic drive_d1_reg;
  logic drive_d2_reg;
  logic fault;
  logic ss_done;
  logic rst_done;

  assign fault = shorted_reg | ch.fb_open;
  assign ss_done = (tmr_reg == TMR_W'(SS_CYC - 1));
  assign rst_done = (tmr_reg == TMR_W'(RST_CYC - 1));
  // Line held low by us but read high means a short to the supply; the drive must have
  // stood through the readback synchroniser first, or a fresh pull would look shorted
  assign shorted_next = ch.en & (shorted_reg | (ch.reset_drive & drive_d1_reg & drive_d2_reg & ch.pin_high));

  always_comb
  begin
    state_next = state_reg;
    tmr_next = tmr_reg + TMR_W'(1);
    if (!ch.en || fault)
    begin
      state_next = WWR_CH_OFF;
      tmr_next = '0;
    end
    else
    begin
      case (state_reg)
        WWR_CH_OFF:
        begin
          state_next = WWR_CH_RAMP;
          tmr_next = '0;
        end
        WWR_CH_RAMP:
          if (ss_done)
          begin
            state_next = WWR_CH_HOLD;
            tmr_next = '0;
          end
        WWR_CH_HOLD:
          if (!ch.in_window)
            tmr_next = '0;
          else if (rst_done)
          begin
            state_next = WWR_CH_GOOD;
            tmr_next = '0;
          end
        default:
        begin
          tmr_next = '0;
          if (!ch.in_window)
            state_next = WWR_CH_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg <= WWR_CH_OFF;
      tmr_reg <= '0;
      shorted_reg <= 1'b0;
      drive_d1_reg <= 1'b0;
      drive_d2_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      shorted_reg <= shorted_next;
      drive_d1_reg <= ch.reset_drive;
      drive_d2_reg <= drive_d1_reg;
    end
  end

  assign ch.run = (state_reg != WWR_CH_OFF) & ~fault;
  assign ch.reset_drive = (state_reg != WWR_CH_GOOD) | ~ch.in_window | ch.wd_reset;
  assign ch.shorted = shorted_reg;
endmodule

/* File: design/wwr_supervisor.sv */
// Windowed watchdog reset supervisor top with Avalon-MM register access
`timescale 1ns/1ps
module wwr_supervisor
  import wwr_pkg::*;
#(
  parameter int P_RST_TIMEOUT_CYC = RST_TIMEOUT_CYC,
  parameter int P_SS_BOOST_CYC = SS_BOOST_CYC,
  parameter int P_SS_BUCK_CYC = SS_BUCK_CYC
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Channel pins
  input wire logic i_boost_channel_enable,
  input wire logic i_buck_a_channel_enable,
  input wire logic i_buck_b_channel_enable,
  input wire logic i_refresh_input,
  input wire logic i_tick_timing_cap_pin,
  output logic o_tick_timing_cap_pin_discharge,
  input wire logic [NUM_CH-1:0] i_out_in_window,
  input wire logic [NUM_CH-1:0] i_out_fb_open,
  input wire logic i_pv_out_of_band,
  // Open-drain reset lines: value, enable (low drives) and pin readback
  input wire logic i_boost_out_reset_n,
  output logic o_boost_out_reset_n,
  output logic o_boost_out_reset_n_oe_n,
  input wire logic i_buck_a_out_reset_n,
  output logic o_buck_a_out_reset_n,
  output logic o_buck_a_out_reset_n_oe_n,
  input wire logic i_buck_b_out_reset_n,
  output logic o_buck_b_out_reset_n,
  output logic o_buck_b_out_reset_n_oe_n,
  // Open-drain input power-good
  output logic o_input_power_good_n,
  output logic o_input_power_good_n_oe_n,
  // Converter run commands
  output logic [NUM_CH-1:0] o_ch_run
);
  localparam int SYN_W = 15;

  // Two-flop synchronisers for all pin inputs
  logic [SYN_W-1:0] pin_raw;
  logic [SYN_W-1:0] sync1_reg;
  logic [SYN_W-1:0] sync2_reg;
  assign pin_raw = {i_pv_out_of_band, i_out_fb_open, i_out_in_window,
                    i_buck_b_out_reset_n, i_buck_a_out_reset_n, i_boost_out_reset_n,
                    i_tick_timing_cap_pin, i_refresh_input,
                    i_buck_b_channel_enable, i_buck_a_channel_enable, i_boost_channel_enable};

  genvar gs;
  generate
    for (gs = 0; gs < SYN_W; gs++)
    begin : g_sync
      always_ff @(posedge i_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          sync1_reg[gs] <= 1'b0;
          sync2_reg[gs] <= 1'b0;
        end
        else
        begin
          sync1_reg[gs] <= pin_raw[gs];
          sync2_reg[gs] <= sync1_reg[gs];
        end
      end
    end
  endgenerate

  logic [NUM_CH-1:0] en_s;
  logic refresh_s;
  logic cap_s;
  logic [NUM_CH-1:0] pin_s;
  logic [NUM_CH-1:0] win_s;
  logic [NUM_CH-1:0] fb_s;
  logic pv_s;
  assign en_s = sync2_reg[2:0];
  assign refresh_s = sync2_reg[3];
  assign cap_s = sync2_reg[4];
  assign pin_s = sync2_reg[7:5];
  assign win_s = sync2_reg[10:8];
  assign fb_s = sync2_reg[13:11];
  assign pv_s = sync2_reg[14];

  // Option register and derived window lengths
  logic [OPT_W-1:0] option_reg;
  logic [NUM_CH-1:0] sup_on;
  logic [TICK_W-1:0] mask_len;
  logic [TICK_W-1:0] ratio;
  logic [TICK_W-1:0] extra;
  logic [TICK_W-1:0] open_len;
  logic [TICK_W-1:0] first_len;
  assign sup_on = option_reg[OPT_SUP_LSB +: NUM_CH];
  assign mask_len = option_reg[OPT_MASK_CNT] ? MASK_TICKS_1 : MASK_TICKS_0;
  assign ratio = option_reg[OPT_RATIO] ? RATIO_1 : RATIO_0;
  assign extra = option_reg[OPT_FIRST_EXTRA] ? FIRST_EXTRA_1 : FIRST_EXTRA_0;
  assign open_len = TICK_W'(mask_len * (ratio + ONE_TICK));
  assign first_len = TICK_W'(mask_len * (ratio + extra));

  // Tick from the timing capacitor comparator
  logic cap_prev_reg;
  logic tick;
  assign tick = cap_s & ~cap_prev_reg;
  assign o_tick_timing_cap_pin_discharge = cap_s;

  // Refresh pulse detection
  logic refresh_prev_reg;
  logic seen_high_reg;
  logic seen_high_next;
  logic refresh_pulse;
  assign refresh_pulse = seen_high_reg & refresh_prev_reg & ~refresh_s;

  // Watchdog sequencer
  wwr_wd_state_t wd_reg;
  wwr_wd_state_t wd_next;
  logic [TICK_W-1:0] ticks_reg;
  logic [TICK_W-1:0] ticks_next;
  logic [TICK_W-1:0] ticks_inc;
  logic [TMR_W-1:0] trip_tmr_reg;
  logic [TMR_W-1:0] trip_tmr_next;
  logic wd_enable;
  logic open_phase;
  assign wd_enable = (|sup_on) & ((sup_on & en_s) == sup_on);
  assign ticks_inc = ticks_reg + ONE_TICK;
  assign open_phase = (wd_reg == WWR_FIRST_OPEN) | (wd_reg == WWR_OPEN);
  assign seen_high_next = open_phase & ~refresh_pulse & (seen_high_reg | refresh_s);

  always_comb
  begin
    wd_next = wd_reg;
    ticks_next = ticks_reg;
    trip_tmr_next = '0;
    if (!wd_enable)
    begin
      wd_next = WWR_IDLE;
      ticks_next = '0;
    end
    else
    begin
      case (wd_reg)
        WWR_IDLE:
        begin
          wd_next = WWR_FIRST_OPEN;
          ticks_next = '0;
        end
        WWR_FIRST_OPEN, WWR_OPEN:
          if (refresh_pulse)
          begin
            wd_next = WWR_MASK;
            ticks_next = '0;
          end
          else if (tick)
          begin
            ticks_next = ticks_inc;
            if (ticks_inc >= ((wd_reg == WWR_OPEN) ? open_len : first_len))
            begin
              wd_next = WWR_TRIP;
              ticks_next = '0;
            end
          end
        WWR_MASK:
          if (tick)
          begin
            ticks_next = ticks_inc;
            if (ticks_inc >= mask_len)
            begin
              wd_next = WWR_OPEN;
              ticks_next = '0;
            end
          end
        default:
        begin
          trip_tmr_next = trip_tmr_reg + TMR_W'(1);
          if (trip_tmr_reg == TMR_W'(P_RST_TIMEOUT_CYC - 1))
          begin
            wd_next = WWR_FIRST_OPEN;
            trip_tmr_next = '0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wd_reg <= WWR_IDLE;
      ticks_reg <= '0;
      trip_tmr_reg <= '0;
      cap_prev_reg <= 1'b0;
      refresh_prev_reg <= 1'b0;
      seen_high_reg <= 1'b0;
    end
    else
    begin
      wd_reg <= wd_next;
      ticks_reg <= ticks_next;
      trip_tmr_reg <= trip_tmr_next;
      cap_prev_reg <= cap_s;
      refresh_prev_reg <= refresh_s;
      seen_high_reg <= seen_high_next;
    end
  end

  // Channel supervisors
  logic [NUM_CH-1:0] reset_drive;
  logic [NUM_CH-1:0] shorted;
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++)
    begin : g_ch
      wwr_ch_if ch_if ();
      assign ch_if.en = en_s[gc];
      assign ch_if.in_window = win_s[gc];
      assign ch_if.pin_high = pin_s[gc];
      assign ch_if.fb_open = fb_s[gc];
      assign ch_if.wd_reset = sup_on[gc] & (wd_reg == WWR_TRIP);
      assign o_ch_run[gc] = ch_if.run;
      assign reset_drive[gc] = ch_if.reset_drive;
      assign shorted[gc] = ch_if.shorted;
      wwr_channel #(
        .SS_CYC((gc == CH_BOOST) ? P_SS_BOOST_CYC : P_SS_BUCK_CYC),
        .RST_CYC(P_RST_TIMEOUT_CYC)
      ) u_channel (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .ch(ch_if.chan)
      );
    end
  endgenerate

  // Open-drain pins: value always low, enable low while pulling
  assign o_boost_out_reset_n = 1'b0;
  assign o_buck_a_out_reset_n = 1'b0;
  assign o_buck_b_out_reset_n = 1'b0;
  assign o_boost_out_reset_n_oe_n = ~reset_drive[CH_BOOST];
  assign o_buck_a_out_reset_n_oe_n = ~reset_drive[CH_BUCK_A];
  assign o_buck_b_out_reset_n_oe_n = ~reset_drive[CH_BUCK_B];
  assign o_input_power_good_n = 1'b0;
  assign o_input_power_good_n_oe_n = (|en_s) & ~pv_s;

  // Avalon-MM slave: one wait cycle per access
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] status_word;
  logic [31:0] rdata_next;
  logic wr_take;
  logic sel_option;
  logic sel_status;
  logic sel_ticks;
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
  assign wr_take = i_avs_write & ~o_avs_waitrequest;
  assign sel_option = (i_avs_address == REG_OPTION);
  assign sel_status = (i_avs_address == REG_STATUS);
  assign sel_ticks = (i_avs_address == REG_TICKS);
  assign status_word = {20'h00000, ST_PHASE_W'(wd_reg), shorted, o_ch_run, reset_drive};
  assign rdata_next = sel_option ? {26'h0000000, option_reg} :
                      sel_status ? status_word :
                      sel_ticks ? {16'h0000, ticks_reg} : 32'h00000000;
  assign o_avs_readdata = rdata_reg;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= '0;
      option_reg <= OPTION_RESET;
    end
    else
    begin
      ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
      if (i_avs_read & ~ack_reg)
        rdata_reg <= rdata_next;
      if (wr_take & sel_option)
        option_reg <= i_avs_writedata[OPT_W-1:0];
    end
  end
endmodule

/* File: tb/wwr_host_model.sv */
// Host-side model that pulses the watchdog refresh pin on request
`timescale 1ns/1ps
module wwr_host_model
(
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [3:0] i_hold_cyc,
  output logic o_refresh
);
  logic [3:0] left_reg = 4'h0;
  always @(posedge i_clk)
    if (i_go)
      left_reg <= i_hold_cyc;
    else if (left_reg != 4'h0)
      left_reg <= left_reg - 4'h1;
  // Low, high for the requested cycles, then low again
  assign o_refresh = (left_reg != 4'h0);
endmodule

/* File: tb/wwr_supervisor_assertions.sv */
// Concurrent checks on the supervisor pins
`timescale 1ns/1ps
module wwr_supervisor_assertions
  import wwr_pkg::*;
#(
  parameter int P_RST_TIMEOUT_CYC = RST_TIMEOUT_CYC
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_boost_channel_enable,
  input wire logic i_buck_a_channel_enable,
  input wire logic i_buck_b_channel_enable,
  input wire logic i_tick_timing_cap_pin,
  input wire logic o_tick_timing_cap_pin_discharge,
  input wire logic [NUM_CH-1:0] i_out_in_window,
  input wire logic [NUM_CH-1:0] i_out_fb_open,
  input wire logic i_pv_out_of_band,
  input wire logic i_boost_out_reset_n,
  input wire logic o_boost_out_reset_n_oe_n,
  input wire logic o_input_power_good_n_oe_n,
  input wire logic [NUM_CH-1:0] o_ch_run
);
  logic en_any;
  logic [TMR_W-1:0] good_cnt_reg;
  assign en_any = i_boost_channel_enable | i_buck_a_channel_enable | i_buck_b_channel_enable;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Cycles the boost output has been enabled and inside its window
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst)
      good_cnt_reg <= '0;
    else if (!(i_out_in_window[0] && i_boost_channel_enable))
      good_cnt_reg <= '0;
    else if (good_cnt_reg != '1)
      good_cnt_reg <= good_cnt_reg + 1'b1;
  a_disch_follows_cap: assert property (i_tick_timing_cap_pin [*2] |-> ##1 o_tick_timing_cap_pin_discharge)
    else $error("discharge off at threshold");
  a_out_window_pull: assert property ((!i_out_in_window[0]) [*3] |-> ##[0:2] !o_boost_out_reset_n_oe_n)
    else $error("reset released out of window");
  a_hold_before_release: assert property ($rose(o_boost_out_reset_n_oe_n) |-> good_cnt_reg >= TMR_W'(P_RST_TIMEOUT_CYC))
    else $error("reset released early");
  a_short_keeps_off: assert property ((!o_boost_out_reset_n_oe_n && i_boost_out_reset_n) [*4] |-> ##[0:3] !o_ch_run[0])
    else $error("runs with shorted reset");
  a_run_needs_enable: assert property ((!i_boost_channel_enable) [*4] |-> !o_ch_run[0])
    else $error("runs while disabled");
  a_fb_open_off: assert property (i_out_fb_open[0] [*4] |-> !o_ch_run[0])
    else $error("runs with open feedback");
  a_pg_shutdown_low: assert property ((!en_any) [*3] |-> ##[0:2] !o_input_power_good_n_oe_n)
    else $error("power-good released in shutdown");
  a_pg_band_low: assert property ((en_any && i_pv_out_of_band) [*3] |-> ##[0:2] !o_input_power_good_n_oe_n)
    else $error("power-good released out of band");
  a_pg_band_high: assert property ((en_any && !i_pv_out_of_band) [*4] |-> ##[0:2] o_input_power_good_n_oe_n)
    else $error("power-good pulled in band");
  cover property ($fell(o_boost_out_reset_n_oe_n) && i_out_in_window[0] && i_boost_channel_enable);
  cover property ($rose(o_input_power_good_n_oe_n));
  cover property ($rose(o_tick_timing_cap_pin_discharge));
endmodule
bind wwr_supervisor wwr_supervisor_assertions #(.P_RST_TIMEOUT_CYC(P_RST_TIMEOUT_CYC)) chk_u (
  .i_clk, .i_rst, .i_boost_channel_enable, .i_buck_a_channel_enable, .i_buck_b_channel_enable,
  .i_tick_timing_cap_pin, .o_tick_timing_cap_pin_discharge, .i_out_in_window, .i_out_fb_open,
  .i_pv_out_of_band, .i_boost_out_reset_n, .o_boost_out_reset_n_oe_n, .o_input_power_good_n_oe_n, .o_ch_run);

/* File: tb/wwr_supervisor_bench.sv */
// Self-checking bench for the watchdog reset supervisor
`timescale 1ns/1ps
module wwr_supervisor_bench
  import wwr_pkg::*;
;
  localparam int RT = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [3:0] av_addr = 4'h0;
  logic [31:0] av_wd = 32'h0;
  logic [31:0] rd_data;
  logic wait_req;
  logic cap = 1'b0;
  logic pv = 1'b0;
  logic go = 1'b0;
  logic [3:0] hold_cyc = 4'h0;
  logic ref_pin;
  logic pg_oe;
  logic [2:0] en = 3'h0;
  logic [2:0] inw = 3'h7;
  logic [2:0] fb = 3'h0;
  logic [2:0] sh = 3'h0;
  logic [2:0] oe;
  logic [2:0] run;
  logic [2:0] pin;
  logic [3:0] od_val;
  int miscompares = 0;
  int check_count = 0;
  // Pulled-up lines read high when released or shorted high
  assign pin = oe | sh;
  always #10 clk = ~clk;
  wwr_supervisor #(.P_RST_TIMEOUT_CYC(RT), .P_SS_BOOST_CYC(10), .P_SS_BUCK_CYC(12)) dut_u (
    .i_clk(clk), .i_rst(rst), .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
    .i_avs_writedata(av_wd), .o_avs_readdata(rd_data), .o_avs_waitrequest(wait_req),
    .i_boost_channel_enable(en[0]), .i_buck_a_channel_enable(en[1]), .i_buck_b_channel_enable(en[2]),
    .i_refresh_input(ref_pin), .i_tick_timing_cap_pin(cap), .o_tick_timing_cap_pin_discharge(),
    .i_out_in_window(inw), .i_out_fb_open(fb), .i_pv_out_of_band(pv),
    .i_boost_out_reset_n(pin[0]), .o_boost_out_reset_n(od_val[0]), .o_boost_out_reset_n_oe_n(oe[0]),
    .i_buck_a_out_reset_n(pin[1]), .o_buck_a_out_reset_n(od_val[1]), .o_buck_a_out_reset_n_oe_n(oe[1]),
    .i_buck_b_out_reset_n(pin[2]), .o_buck_b_out_reset_n(od_val[2]), .o_buck_b_out_reset_n_oe_n(oe[2]),
    .o_input_power_good_n(od_val[3]), .o_input_power_good_n_oe_n(pg_oe), .o_ch_run(run));
  wwr_host_model host_u (.i_clk(clk), .i_go(go), .i_hold_cyc(hold_cyc), .o_refresh(ref_pin));
  task automatic results;
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    av_addr <= a;
    av_wd <= d;
    av_wr <= wr;
    av_rd <= !wr;
    // Request stands until the rising edge that samples waitrequest low
    do
      @(posedge clk);
    while (wait_req !== 1'b0);
    q = rd_data;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask
  task automatic phase(input logic [2:0] exp);
    logic [31:0] q;
    bus(1'b0, REG_STATUS, 32'h0, q);
    chk({29'h0, q[ST_PHASE_LSB +: ST_PHASE_W]}, {29'h0, exp});
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      cap <= 1'b1;
      cyc(2);
      cap <= 1'b0;
      cyc(2);
    end
  endtask
  task automatic refresh(input logic [3:0] hold);
    go <= 1'b1;
    hold_cyc <= hold;
    @(posedge clk);
    go <= 1'b0;
    cyc(16);
  endtask
  task automatic reg_test;
    logic [31:0] q;
    bus(1'b0, REG_OPTION, 32'h0, q);
    chk(q, {26'h0, OPTION_RESET});
    bus(1'b1, REG_OPTION, 32'hffff_ffff, q);
    bus(1'b0, REG_OPTION, 32'h0, q);
    chk(q, 32'h0000_003f);
    bus(1'b1, 4'hc, 32'h0000_0015, q);
    bus(1'b0, 4'hc, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b1, REG_OPTION, 32'h0, q);
  endtask
  task automatic ch_test;
    chk({31'h0, pg_oe}, 32'h0);
    chk({28'h0, od_val}, 32'h0);
    en <= 3'h1;
    cyc(6);
    chk({29'h0, run}, 32'h1);
    chk({31'h0, pg_oe}, 32'h1);
    pv <= 1'b1;
    cyc(5);
    chk({31'h0, pg_oe}, 32'h0);
    pv <= 1'b0;
    // Release due 2 sync edges + 1 + ramp 10 + timeout RT after the enable
    cyc(21);
    chk({29'h0, oe}, 32'h0);
    cyc(2);
    chk({29'h0, oe}, 32'h1);
    inw <= 3'h6;
    cyc(5);
    chk({29'h0, oe}, 32'h0);
    inw <= 3'h7;
    fb <= 3'h1;
    cyc(5);
    chk({29'h0, run}, 32'h0);
    fb <= 3'h0;
    en <= 3'h0;
    cyc(5);
    sh <= 3'h1;
    en <= 3'h1;
    cyc(10);
    chk({29'h0, run}, 32'h0);
    en <= 3'h0;
    sh <= 3'h0;
    cyc(5);
  endtask
  task automatic wd_case(input logic [5:0] opt, input logic [2:0] sup, input int first_n, input int mask_n,
                         input int open_n);
    logic [31:0] q;
    en <= ~sup;
    bus(1'b1, REG_OPTION, {26'h0, opt}, q);
    tick(3);
    phase(3'h0);
    en <= 3'h7;
    cyc(60);
    chk({29'h0, oe}, 32'h7);
    phase(3'h1);
    tick(first_n - 1);
    phase(3'h1);
    bus(1'b0, REG_TICKS, 32'h0, q);
    chk(q, first_n - 1);
    tick(1);
    phase(3'h4);
    chk({29'h0, oe}, {29'h0, ~sup});
    cyc(RT + 5);
    phase(3'h1);
    refresh(4'h3);
    phase(3'h2);
    tick(mask_n / 2);
    refresh(4'h8);
    tick(mask_n / 2 - 1);
    phase(3'h2);
    tick(1);
    phase(3'h3);
    tick(open_n - 1);
    phase(3'h3);
    tick(1);
    phase(3'h4);
    en <= 3'h0;
    cyc(RT + 10);
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    reg_test();
    ch_test();
    wd_case(6'h01, 3'h1, 1152, 16, 144);
    wd_case(6'h12, 3'h2, 4608, 64, 576);
    wd_case(6'h2c, 3'h4, 2304, 16, 272);
    results();
  end
  initial
  begin
    #2000000;
    miscompares++;
    results();
  end
endmodule
